// [common/twx_pkg.sv]
// types shared by the execute unit
package twx_pkg;
    typedef enum logic [1:0] {
        st_exec,
        st_tbl2,
        st_skip1,
        st_skip2
    } twx_state_t;

    typedef struct packed {
        logic [1:0]  phase;
        twx_state_t  st;
        logic [15:0] ir;
        logic [7:0]  fdata;
        logic [7:0]  tlat;
        logic [7:0]  w;
        logic        flag_n;
        logic        flag_z;
        logic [21:0] tptr;
        logic        discard;
        logic        two_word;
    } twx_regs_t;
endpackage

// [common/twx_regs.svh]
// reset values, field positions and timing counts of the execute unit
`ifndef TWX_REGS_SVH
`define TWX_REGS_SVH
`define TWX_PHASES          4
`define TWX_PHASE_Q1        2'h0
`define TWX_PHASE_Q2        2'h1
`define TWX_PHASE_Q3        2'h2
`define TWX_PHASE_Q4        2'h3
`define TWX_OP_XOR_LIT_HI   8'h0a
`define TWX_OP_TST_SKIP_HI  7'h33
`define TWX_OP_TBL_WR_HI    14'h0003
`define TWX_TBL_PLAIN       2'h0
`define TWX_TBL_POSTINC     2'h1
`define TWX_TBL_POSTDEC     2'h2
`define TWX_TBL_PREINC      2'h3
`define TWX_ACCESS_SPLIT    8'h60
`define TWX_ACCESS_HI_BANK  4'hf
`define TWX_ACCESS_LO_BANK  4'h0
`define TWX_HOLD_DEPTH      8
`define TWX_RST_W           8'h00
`define TWX_RST_IR          16'hffff
`define TWX_RST_TPTR        22'h000000
`define TWX_RST_BYTE        8'h00
`endif

// [logic/twx_exec.sv]
// execute stage for table write, test-and-skip and xor-literal
//
// What this block does
// RQ1: post-increment table write stores latch at pointer, then pointer plus one.
// RQ2: pre-increment table write adds one first, then stores at new pointer.
// RQ3: table write takes two cycles; second cycle reads latch, loads holding.
// RQ4: test-and-skip decodes 0110 011a plus file address; no flag changes.
// RQ5: zero tested register discards the fetched instruction, runs a nop.
// RQ6: test-and-skip takes one cycle, two when skipping a one-word one.
// RQ7: skipping a two-word instruction inserts two nop cycles, three total.
// RQ8: access bit zero addresses the register through the access bank.
// RQ9: access bit one takes the bank from the bank select register.
// RQ10: extended set with access zero makes addresses up to 95 indexed.
// RQ11: xor-literal xors working register with literal, result back to it.
// RQ12: xor-literal opcode is 0000 1010 high byte, literal low byte.
// RQ13: xor-literal updates only the negative and zero flags.
`timescale 1ns/10ps
`include "twx_regs.svh"
module twx_exec (
    sys_clk,
    rst,
    instr_valid,
    instr_word,
    next_is_two_word,
    ext_set_enable,
    bank_select_register,
    fsr2_value,
    file_data,
    table_latch,
    tptr_load,
    tptr_load_value,
    hold_rd_idx,
    instr_ready,
    cycle_end,
    file_addr,
    discard_fetched,
    nop_active,
    accum,
    flag_n,
    flag_z,
    table_pointer,
    hold_rd_data
);
    input  wire logic        sys_clk;
    input  wire logic        rst;
    input  wire logic        instr_valid;
    input  wire logic [15:0] instr_word;
    input  wire logic        next_is_two_word;
    input  wire logic        ext_set_enable;
    input  wire logic [3:0]  bank_select_register;
    input  wire logic [11:0] fsr2_value;
    input  wire logic [7:0]  file_data;
    input  wire logic [7:0]  table_latch;
    input  wire logic        tptr_load;
    input  wire logic [21:0] tptr_load_value;
    input  wire logic [2:0]  hold_rd_idx;
    output logic             instr_ready;
    output logic             cycle_end;
    output logic      [11:0] file_addr;
    output logic             discard_fetched;
    output logic             nop_active;
    output logic      [7:0]  accum;
    output logic             flag_n;
    output logic             flag_z;
    output logic      [21:0] table_pointer;
    output logic      [7:0]  hold_rd_data;

    twx_pkg::twx_regs_t r_reg;
    twx_pkg::twx_regs_t r_next;

    logic       hold_wr_en;
    logic [2:0] hold_wr_idx;
    logic       take;
    logic       commit;

    function automatic logic is_xor_lit(input logic [15:0] iw);
        is_xor_lit = (iw[15:8] == `TWX_OP_XOR_LIT_HI); // RQ12
    endfunction

    function automatic logic is_tst_skip(input logic [15:0] iw);
        is_tst_skip = (iw[15:9] == `TWX_OP_TST_SKIP_HI); // RQ4
    endfunction

    function automatic logic is_tbl_wr(input logic [15:0] iw);
        is_tbl_wr = (iw[15:2] == `TWX_OP_TBL_WR_HI);
    endfunction

    // operand address from file field, access bit and bank state
    function automatic logic [11:0] form_addr(
        input logic [7:0]  f,
        input logic        a,
        input logic        ext,
        input logic [3:0]  bank,
        input logic [11:0] fsr2
    );
        if (a) begin
            form_addr = {bank, f}; // RQ9
        end else if (ext && (f < `TWX_ACCESS_SPLIT)) begin
            form_addr = fsr2 + {4'h0, f}; // RQ10
        end else if (f < `TWX_ACCESS_SPLIT) begin
            form_addr = {`TWX_ACCESS_LO_BANK, f}; // RQ8
        end else begin
            form_addr = {`TWX_ACCESS_HI_BANK, f}; // RQ8
        end
    endfunction

    assign take        = (r_reg.st == twx_pkg::st_exec) &&
                         (r_reg.phase == `TWX_PHASE_Q1) && instr_valid;
    assign commit      = (r_reg.st == twx_pkg::st_exec) &&
                         (r_reg.phase == `TWX_PHASE_Q4);
    assign instr_ready = (r_reg.st == twx_pkg::st_exec) &&
                         (r_reg.phase == `TWX_PHASE_Q1);
    assign cycle_end   = (r_reg.phase == `TWX_PHASE_Q4);
    assign file_addr   = form_addr(r_reg.ir[7:0], r_reg.ir[8],
                                   ext_set_enable, bank_select_register,
                                   fsr2_value);
    assign discard_fetched = r_reg.discard;
    assign nop_active  = (r_reg.st == twx_pkg::st_skip1) ||
                         (r_reg.st == twx_pkg::st_skip2);
    assign accum         = r_reg.w;
    assign flag_n        = r_reg.flag_n;
    assign flag_z        = r_reg.flag_z;
    assign table_pointer = r_reg.tptr;

    // holding write lands in the last phase of the second cycle
    assign hold_wr_en  = (r_reg.st == twx_pkg::st_tbl2) &&
                         (r_reg.phase == `TWX_PHASE_Q4); // RQ3
    assign hold_wr_idx = (r_reg.ir[1:0] == `TWX_TBL_PREINC) ?
                         r_reg.tptr[2:0] + 3'h1 : // RQ2
                         r_reg.tptr[2:0]; // RQ1

    always_comb begin
        r_next         = r_reg;
        r_next.phase   = r_reg.phase + 2'h1;
        r_next.discard = 1'b0;
        if (tptr_load) begin
            r_next.tptr = tptr_load_value;
        end
        unique case (r_reg.st)
            twx_pkg::st_exec: begin
                if (take) begin
                    r_next.ir = instr_word;
                    r_next.two_word = 1'b0;
                end else if (r_reg.phase == `TWX_PHASE_Q1) begin
                    // no instruction: hold an opcode that decodes to nothing
                    r_next.ir = `TWX_RST_IR;
                end
                if (r_reg.phase == `TWX_PHASE_Q2) begin
                    r_next.fdata = file_data;
                end
                if (r_reg.phase == `TWX_PHASE_Q3) begin
                    r_next.two_word = next_is_two_word;
                end
                if (commit && is_xor_lit(r_reg.ir)) begin
                    r_next.w      = r_reg.w ^ r_reg.ir[7:0]; // RQ11
                    r_next.flag_n = r_next.w[7]; // RQ13
                    r_next.flag_z = (r_next.w == `TWX_RST_W); // RQ13
                end
                if (commit && is_tst_skip(r_reg.ir) &&
                    (r_reg.fdata == `TWX_RST_BYTE)) begin
                    r_next.discard = 1'b1; // RQ5
                    r_next.st = r_reg.two_word ?
                                twx_pkg::st_skip2 :
                                twx_pkg::st_skip1; // RQ6 RQ7
                end
                if (commit && is_tbl_wr(r_reg.ir)) begin
                    r_next.st = twx_pkg::st_tbl2; // RQ3
                end
            end
            twx_pkg::st_tbl2: begin
                if (r_reg.phase == `TWX_PHASE_Q2) begin
                    r_next.tlat = table_latch; // RQ3
                end
                if (hold_wr_en) begin
                    unique case (r_reg.ir[1:0])
                        `TWX_TBL_PLAIN:   r_next.tptr = r_reg.tptr;
                        `TWX_TBL_POSTINC: r_next.tptr = r_reg.tptr + 22'h1;
                        `TWX_TBL_POSTDEC: r_next.tptr = r_reg.tptr - 22'h1;
                        `TWX_TBL_PREINC:  r_next.tptr = r_reg.tptr + 22'h1;
                    endcase
                    r_next.st = twx_pkg::st_exec;
                end
            end
            twx_pkg::st_skip2: begin
                // second word of the skipped instruction burns one more nop
                if (r_reg.phase == `TWX_PHASE_Q4) begin
                    r_next.st = twx_pkg::st_skip1; // RQ7
                end
            end
            twx_pkg::st_skip1: begin
                if (r_reg.phase == `TWX_PHASE_Q4) begin
                    r_next.st = twx_pkg::st_exec; // RQ6
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r_reg.phase    <= `TWX_PHASE_Q1;
            r_reg.st       <= twx_pkg::st_exec;
            r_reg.ir       <= `TWX_RST_IR;
            r_reg.fdata    <= `TWX_RST_BYTE;
            r_reg.tlat     <= `TWX_RST_BYTE;
            r_reg.w        <= `TWX_RST_W;
            r_reg.flag_n   <= 1'b0;
            r_reg.flag_z   <= 1'b0;
            r_reg.tptr     <= `TWX_RST_TPTR;
            r_reg.discard  <= 1'b0;
            r_reg.two_word <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    twx_hold_mem u_hold (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (hold_wr_en),
        .wr_idx  (hold_wr_idx),
        .wr_data (r_reg.tlat),
        .rd_idx  (hold_rd_idx),
        .rd_data (hold_rd_data)
    );

    // helpers watched only by the checks below
    logic       tbl_take;
    logic       tst_zero_commit;
    logic       xor_commit;
    logic       post_wr;
    logic       pre_wr;
    logic [7:0] lit;
    assign tbl_take = take && is_tbl_wr(instr_word);
    assign tst_zero_commit = commit && is_tst_skip(r_reg.ir) &&
                             (r_reg.fdata == `TWX_RST_BYTE);
    assign xor_commit = commit && is_xor_lit(r_reg.ir);
    assign post_wr = hold_wr_en && (r_reg.ir[1:0] == `TWX_TBL_POSTINC);
    assign pre_wr  = hold_wr_en && (r_reg.ir[1:0] == `TWX_TBL_PREINC);
    assign lit     = r_reg.ir[7:0];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_post_inc_ptr: assert property ( // RQ1
        post_wr && !tptr_load |-> hold_wr_idx == r_reg.tptr[2:0]
        ##1 r_reg.tptr == $past(r_reg.tptr) + 22'h1)
        else $error("post-increment write slot or pointer wrong");
    a_pre_inc_addr: assert property ( // RQ2
        pre_wr && !tptr_load |-> hold_wr_idx == r_reg.tptr[2:0] + 3'h1
        ##1 r_reg.tptr[2:0] == $past(hold_wr_idx))
        else $error("pre-increment write slot wrong");
    a_table_two_cyc: assert property ( // RQ3
        tbl_take |-> !hold_wr_en [*7] ##1 hold_wr_en ##1 instr_ready)
        else $error("table write not two cycles");
    a_tst_no_flags: assert property ( // RQ4
        commit && is_tst_skip(r_reg.ir) |=> $stable(flag_n) && $stable(flag_z))
        else $error("test-and-skip changed a flag");
    a_skip_discard: assert property ( // RQ5
        tst_zero_commit |=> discard_fetched ##1 !discard_fetched)
        else $error("zero test did not discard the fetched word");
    a_skip_one_word: assert property ( // RQ6
        tst_zero_commit && !r_reg.two_word |=> nop_active [*4]
        ##1 !nop_active)
        else $error("one-word skip not one nop cycle");
    a_skip_two_word: assert property ( // RQ7
        tst_zero_commit && r_reg.two_word |=> nop_active [*8]
        ##1 !nop_active)
        else $error("two-word skip not two nop cycles");
    a_no_skip_nz: assert property ( // RQ6
        commit && is_tst_skip(r_reg.ir) && r_reg.fdata != `TWX_RST_BYTE
        |=> !nop_active)
        else $error("skip taken on nonzero register");
    a_bank_addr: assert property ( // RQ9
        r_reg.ir[8] |-> file_addr == {bank_select_register, r_reg.ir[7:0]})
        else $error("banked address wrong");
    a_access_addr: assert property ( // RQ8 RQ10
        !r_reg.ir[8] && !ext_set_enable && r_reg.ir[7:0] < 8'h60
        |-> file_addr == {4'h0, r_reg.ir[7:0]})
        else $error("access bank address wrong");
    a_xor_result: assert property ( // RQ11 RQ12
        xor_commit |=> accum == ($past(accum) ^ $past(lit)))
        else $error("xor result wrong");
    a_xor_flags: assert property ( // RQ13
        xor_commit |=> flag_n == accum[7] && flag_z == (accum == 8'h00))
        else $error("xor flags wrong");

    c_tbl_post: cover property (post_wr);
    c_tbl_pre: cover property (pre_wr);
    c_skip_one: cover property (tst_zero_commit && !r_reg.two_word);
    c_skip_two: cover property (tst_zero_commit && r_reg.two_word);
endmodule

// [logic/twx_hold_mem.sv]
// holding register array for table writes, registered read port
`timescale 1ns/10ps
`include "twx_regs.svh"
module twx_hold_mem (
    sys_clk,
    rst,
    wr_en,
    wr_idx,
    wr_data,
    rd_idx,
    rd_data
);
    input  wire logic       sys_clk;
    input  wire logic       rst;
    input  wire logic       wr_en;
    input  wire logic [2:0] wr_idx;
    input  wire logic [7:0] wr_data;
    input  wire logic [2:0] rd_idx;
    output logic      [7:0] rd_data;

    logic [7:0] mem [0:`TWX_HOLD_DEPTH-1];

    // erased flash reads ones, so the array need not be reset
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data <= `TWX_RST_BYTE;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule

// [test/twx_exec_bench.sv]
// self-checking bench for the execute stage
`timescale 1ns/10ps
module twx_exec_bench;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        instr_valid = 1'b0;
    logic [15:0] instr_word = 16'hffff;
    logic        next_is_two_word = 1'b0;
    logic        ext_set_enable = 1'b0;
    logic [3:0]  bank_select_register = 4'h5;
    logic [11:0] fsr2_value = 12'h300;
    logic [7:0]  file_data = 8'h01;
    logic [7:0]  table_latch = 8'h00;
    logic        tptr_load = 1'b0;
    logic [21:0] tptr_load_value = 22'h000000;
    logic [2:0]  hold_rd_idx = 3'h0;
    logic        instr_ready, cycle_end, discard_fetched, nop_active;
    logic        flag_n, flag_z;
    logic [11:0] file_addr;
    logic [7:0]  accum, hold_rd_data;
    logic [21:0] table_pointer;
    int          failures = 0;
    int          cmp_count = 0;
    int          clks;
    logic        disc, nops, ends;
    logic [11:0] fa;

    twx_exec uut (.sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .next_is_two_word(next_is_two_word),
        .ext_set_enable(ext_set_enable),
        .bank_select_register(bank_select_register),
        .fsr2_value(fsr2_value), .file_data(file_data),
        .table_latch(table_latch), .tptr_load(tptr_load),
        .tptr_load_value(tptr_load_value), .hold_rd_idx(hold_rd_idx),
        .instr_ready(instr_ready), .cycle_end(cycle_end),
        .file_addr(file_addr), .discard_fetched(discard_fetched),
        .nop_active(nop_active), .accum(accum), .flag_n(flag_n),
        .flag_z(flag_z), .table_pointer(table_pointer),
        .hold_rd_data(hold_rd_data));

    always #12.5 sys_clk = ~sys_clk;

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // offer one word, wait for the take, then count clocks until free again
    task automatic issue(input logic [15:0] w);
        int n;
        n = 0;
        @(posedge sys_clk);
        instr_valid <= 1'b1;
        instr_word  <= w;
        #1;
        while (instr_ready !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("instr ready", instr_ready, 1);
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        instr_word  <= 16'hffff;
        #1;
        fa = file_addr;
        clks = 1;
        disc = 1'b0;
        nops = 1'b0;
        ends = 1'b0;
        while (instr_ready !== 1'b1 && clks < 40) begin
            disc |= (discard_fetched === 1'b1);
            nops |= (nop_active === 1'b1);
            ends |= (cycle_end === 1'b1);
            @(posedge sys_clk);
            #1;
            clks++;
        end
    endtask

    task automatic test_reset;
        check("ready", instr_ready, 1);
        check("accum", accum, 0);
        check("flags", {flag_n, flag_z}, 0);
        check("pointer", table_pointer, 0);
        check("nop", nop_active, 0);
        check("discard", discard_fetched, 0);
        check("holding out", hold_rd_data, 0);
    endtask

    task automatic test_xor;
        logic [15:0] ws [4] = '{16'h0a80, 16'h0a80, 16'h0a5a, 16'h0b5a};
        logic [7:0]  ew [4] = '{8'h80, 8'h00, 8'h5a, 8'h5a};
        logic [1:0]  ef [4] = '{2'b10, 2'b01, 2'b00, 2'b00};
        for (int i = 0; i < 4; i++) begin
            issue(ws[i]);
            check("xor accum", accum, ew[i]);
            check("xor flags", {flag_n, flag_z}, ef[i]);
            check("xor clocks", clks, 4);
            check("xor cycle end", ends, 1);
        end
    endtask

    task automatic test_skip;
        logic [7:0] fd [3] = '{8'h00, 8'h01, 8'h00};
        logic       tw [3] = '{1'b0, 1'b0, 1'b1};
        int         ec [3] = '{8, 4, 12};
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            file_data        <= fd[i];
            next_is_two_word <= tw[i];
            issue(16'h6620);
            check("skip clocks", clks, ec[i]);
            check("skip discard", disc, fd[i] == 0);
            check("skip nop", nops, fd[i] == 0);
            check("skip accum", accum, 8'h5a);
            check("skip flags", {flag_n, flag_z}, 0);
        end
        @(posedge sys_clk);
        file_data        <= 8'h01;
        next_is_two_word <= 1'b0;
    endtask

    task automatic test_bank;
        logic [15:0] ws [7] = '{16'h6620, 16'h6680, 16'h6712, 16'h6610,
                                16'h6660, 16'h665f, 16'h6712};
        logic [11:0] ea [7] = '{12'h020, 12'hf80, 12'h512, 12'h310,
                                12'hf60, 12'h35f, 12'h512};
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            ext_set_enable <= (i >= 3);
            issue(ws[i]);
            check("operand address", fa, ea[i]);
        end
        @(posedge sys_clk);
        ext_set_enable <= 1'b0;
    endtask

    // every write mode from the same start pointer
    task automatic test_table;
        logic [21:0] ep [4] = '{22'h01389a, 22'h01389b, 22'h013899,
                                22'h01389b};
        logic [2:0]  ei [4] = '{3'h2, 3'h2, 3'h2, 3'h3};
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk);
            tptr_load       <= 1'b1;
            tptr_load_value <= 22'h01389a;
            table_latch     <= 8'h30 + 8'(m);
            @(posedge sys_clk);
            tptr_load <= 1'b0;
            issue(16'h000c | 16'(m));
            check("table clocks", clks, 8);
            check("table pointer", table_pointer, ep[m]);
            @(posedge sys_clk);
            hold_rd_idx <= ei[m];
            @(posedge sys_clk);
            @(posedge sys_clk);
            #1;
            check("holding data", hold_rd_data, 8'h30 + m);
        end
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        // look before the first free edge: that edge moves the phase on
        #1;
        test_reset();
        test_xor();
        test_skip();
        test_bank();
        test_table();
        report_and_stop();
    end

    // whole run needs well under a thousand clocks
    initial begin
        #(25 * 4000);
        failures++;
        report_and_stop();
    end
endmodule
